/* File: core/tmcc_capture_front.sv */
// capture pin noise filter and edge detector
`include "tmcc_consts.svh"

module tmcc_capture_front (
  // clock and reset
  input wire logic    clk_sys_i,
  input wire logic    nrst_i,
  // link to the timer core
  tmcc_cap_if.front   cap
);

  tmcc_pkg::tmcc_front_t s_r;
  tmcc_pkg::tmcc_front_t s_nxt;

  // the sample history is a fixed four-bit field, so any other depth is refused
  if (`TMCC_FILT_DEPTH != 4) begin : g_depth_chk
    $error("filter depth must be four");
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt         = s_r;
    s_nxt.hist    = {s_r.hist[2:0], cap.pin};
    s_nxt.event_p = 1'b0;
    if (cap.filter_en) begin
      // level moves only once all four stored samples agree, four cycles late
      if ((&s_r.hist) || (~|s_r.hist)) begin
        s_nxt.level = s_r.hist[0];
      end
    end else begin
      s_nxt.level = cap.pin;
    end
    // ignored pin in capture-as-top modes, edge chosen by select bit
    if (cap.enable && (s_nxt.level != s_r.level) && (s_nxt.level == cap.rise_sel)) begin
      s_nxt.event_p = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cap.cap_event = s_r.event_p;

endmodule : tmcc_capture_front

/* File: core/tmcc_timer_top.sv */
// two 16-bit timer/counters with byte-wide register port and capture
`include "tmcc_consts.svh"

module tmcc_timer_top (
  // clock and reset
  input  wire logic                        clk_sys_i,
  input  wire logic                        nrst_i,
  // byte-wide register port
  input  wire logic [`TMCC_ADDR_W-1:0]     addr_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  input  wire logic [7:0]                  wdata_i,
  output logic      [7:0]                  rdata_o,
  // low waveform mode bits from control register a, per instance
  input  wire logic [1:0][1:0]             mode_lower_i,
  // pins
  input  wire logic [1:0]                  capture_pin_i,
  input  wire logic                        external_count_pin_i,
  // timer state and events, per instance
  output logic      [1:0][15:0]            counter_value_o,
  output logic      [1:0][15:0]            capture_register_o,
  output logic      [1:0]                  capture_flag_set_o,
  output logic      [1:0]                  match_a_o,
  output logic      [1:0]                  match_b_o
);

  tmcc_pkg::tmcc_state_t s_r;
  tmcc_pkg::tmcc_state_t s_nxt;
  logic [1:0]            cap_ev;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // four-bit waveform mode code
  function automatic logic [3:0] mode_of(input logic [7:0] cb, input logic [1:0] lo);
    mode_of = {cb[`TMCC_MODE_HI:`TMCC_MODE_LO], lo};
  endfunction : mode_of

  // modes 8, 10, 12 and 14 take the capture register as top
  function automatic logic icr_top(input logic [3:0] m);
    icr_top = m[3] && !m[0] && (m != 4'h0);
  endfunction : icr_top

  // dual slope modes count up then down
  function automatic logic dual_slope(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: dual_slope = 1'b1;
      default:                                  dual_slope = 1'b0;
    endcase
  endfunction : dual_slope

  // top value of the counting sequence; reserved mode 13 runs to full scale
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a, input logic [15:0] ic);
    case (m)
      4'h1, 4'h5:                top_of = `TMCC_TOP_8BIT;
      4'h2, 4'h6:                top_of = `TMCC_TOP_9BIT;
      4'h3, 4'h7:                top_of = `TMCC_TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf:    top_of = a;
      4'h8, 4'ha, 4'hc, 4'he:    top_of = ic;
      default:                   top_of = `TMCC_TOP_MAX;
    endcase
  endfunction : top_of

  // one timer tick from the shared prescaler or the external pin
  function automatic logic tick_of(input logic [2:0] cs, input logic inst3, input logic [9:0] pre,
                                   input logic ext_rise, input logic ext_fall);
    case (cs)
      `TMCC_CS_STOP:    tick_of = 1'b0;
      `TMCC_CS_DIV1:    tick_of = 1'b1;
      `TMCC_CS_DIV8:    tick_of = &pre[`TMCC_LOG_DIV8-1:0];
      `TMCC_CS_DIV64:   tick_of = &pre[`TMCC_LOG_DIV64-1:0];
      `TMCC_CS_DIV256:  tick_of = &pre[`TMCC_LOG_DIV256-1:0];
      `TMCC_CS_DIV1024: tick_of = &pre[`TMCC_LOG_DIV1024-1:0];
      `TMCC_CS_CODE6:   tick_of = inst3 ? (&pre[`TMCC_LOG_DIV16-1:0]) : ext_fall;
      `TMCC_CS_CODE7:   tick_of = inst3 ? (&pre[`TMCC_LOG_DIV32-1:0]) : ext_rise;
      default:          tick_of = 1'b0;
    endcase
  endfunction : tick_of

  ////////////////////////////////////////////////////////////////////////////
  // capture front ends, one per instance

  tmcc_cap_if cif[2] ();

  for (genvar g = 0; g < 2; g++) begin : g_cap
    assign cif[g].pin       = capture_pin_i[g];
    assign cif[g].filter_en = s_r.ctrlb[g][`TMCC_BIT_FILTER];
    assign cif[g].rise_sel  = s_r.ctrlb[g][`TMCC_BIT_EDGE];
    assign cif[g].enable    = !icr_top(mode_of(s_r.ctrlb[g], mode_lower_i[g]));
    assign cap_ev[g]        = cif[g].cap_event;

    tmcc_capture_front u_front (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .cap       (cif[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic       ext_rise;
    logic       ext_fall;
    logic       tk;
    logic [3:0] md;
    logic [15:0] top;
    logic       t;
    logic [2:0] sub;
    logic       hit;
    ext_rise = 1'b0;
    ext_fall = 1'b0;
    tk       = 1'b0;
    md       = 4'h0;
    top      = `TMCC_RST_WORD;
    t        = addr_i[3];
    sub      = addr_i[2:0];
    hit      = (addr_i[4] == 1'b0) && (addr_i[2:0] != 3'h7);

    s_nxt          = s_r;
    s_nxt.pre      = s_r.pre + 10'h001;
    s_nxt.match_a  = 2'b00;
    s_nxt.match_b  = 2'b00;
    s_nxt.cap_set  = 2'b00;
    // pin sampled whatever its direction, so software can clock the counter
    s_nxt.ext_prev = external_count_pin_i;
    ext_rise       = external_count_pin_i && !s_r.ext_prev;
    ext_fall       = !external_count_pin_i && s_r.ext_prev;

    for (int i = 0; i < 2; i++) begin
      md  = mode_of(s_r.ctrlb[i], mode_lower_i[i]);
      top = top_of(md, s_r.cmpa[i], s_r.icr[i]);
      tk  = tick_of(s_r.ctrlb[i][`TMCC_CS_HI:0], i[0], s_r.pre, ext_rise, ext_fall);

      // capture takes the counter as it stands when the event arrives
      if (cap_ev[i]) begin
        s_nxt.icr[i]     = s_r.cnt[i];
        s_nxt.cap_set[i] = 1'b1;
      end

      if (tk) begin
        if (s_r.blocked[i]) begin
          // first tick after a counter write gives no match
          s_nxt.blocked[i] = 1'b0;
        end else begin
          s_nxt.match_a[i] = (s_r.cnt[i] == s_r.cmpa[i]);
          s_nxt.match_b[i] = (s_r.cnt[i] == s_r.cmpb[i]);
        end
        if (dual_slope(md)) begin
          if (!s_r.dir_down[i]) begin
            if (s_r.cnt[i] >= top) begin
              s_nxt.dir_down[i] = 1'b1;
              s_nxt.cnt[i]      = s_r.cnt[i] - `TMCC_ONE_WORD;
            end else begin
              s_nxt.cnt[i] = s_r.cnt[i] + `TMCC_ONE_WORD;
            end
          end else begin
            if (s_r.cnt[i] == `TMCC_RST_WORD) begin
              s_nxt.dir_down[i] = 1'b0;
              s_nxt.cnt[i]      = `TMCC_ONE_WORD;
            end else begin
              s_nxt.cnt[i] = s_r.cnt[i] - `TMCC_ONE_WORD;
            end
          end
        end else begin
          s_nxt.dir_down[i] = 1'b0;
          // a counter beyond top, after a write, runs on through full scale
          if (s_r.cnt[i] == top) begin
            s_nxt.cnt[i] = `TMCC_RST_WORD;
          end else begin
            s_nxt.cnt[i] = s_r.cnt[i] + `TMCC_ONE_WORD;
          end
        end
      end
    end

    // register writes; a counter write wins over the tick in the same cycle
    if (wr_i && hit) begin
      case (sub)
        `TMCC_SUB_CTRLB: begin
          s_nxt.ctrlb[t] = wdata_i & `TMCC_CTRLB_WMASK;
        end
        `TMCC_SUB_CNT_H, `TMCC_SUB_CMPA_H, `TMCC_SUB_CMPB_H: begin
          // every high byte goes to the one shared latch
          s_nxt.temp = wdata_i;
        end
        `TMCC_SUB_CNT_L: begin
          s_nxt.cnt[t]     = {s_r.temp, wdata_i};
          s_nxt.blocked[t] = 1'b1;
        end
        `TMCC_SUB_CMPA_L: begin
          s_nxt.cmpa[t] = {s_r.temp, wdata_i};
        end
        `TMCC_SUB_CMPB_L: begin
          s_nxt.cmpb[t] = {s_r.temp, wdata_i};
        end
        default: begin
        end
      endcase
    end

    // register reads; answer appears one cycle after the strobe
    if (rd_i) begin
      s_nxt.rdata = `TMCC_RST_BYTE;
      if (hit) begin
        case (sub)
          `TMCC_SUB_CTRLB: begin
            s_nxt.rdata = s_r.ctrlb[t];
          end
          `TMCC_SUB_CNT_L: begin
            // low read snapshots the high byte so a later high read matches it
            s_nxt.rdata = s_r.cnt[t][7:0];
            s_nxt.temp  = s_r.cnt[t][15:8];
          end
          `TMCC_SUB_CNT_H: begin
            s_nxt.rdata = s_r.temp;
          end
          `TMCC_SUB_CMPA_L: begin
            s_nxt.rdata = s_r.cmpa[t][7:0];
          end
          `TMCC_SUB_CMPA_H: begin
            s_nxt.rdata = s_r.cmpa[t][15:8];
          end
          `TMCC_SUB_CMPB_L: begin
            s_nxt.rdata = s_r.cmpb[t][7:0];
          end
          `TMCC_SUB_CMPB_H: begin
            s_nxt.rdata = s_r.cmpb[t][15:8];
          end
          default: begin
            s_nxt.rdata = `TMCC_RST_BYTE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign rdata_o            = s_r.rdata;
  assign counter_value_o    = s_r.cnt;
  assign capture_register_o = s_r.icr;
  assign capture_flag_set_o = s_r.cap_set;
  assign match_a_o          = s_r.match_a;
  assign match_b_o          = s_r.match_b;

endmodule : tmcc_timer_top

/* File: dv/tmcc_timer_properties.sv */
// checker for register port, counting, match blanking and capture of timer one
`include "tmcc_consts.svh"
module tmcc_timer_chk (
  // clock and reset
  input wire logic                    clk_sys_i,
  input wire logic                    nrst_i,
  // register port
  input wire logic [`TMCC_ADDR_W-1:0] addr_i,
  input wire logic                    wr_i,
  input wire logic                    rd_i,
  input wire logic [7:0]              wdata_i,
  input wire logic [7:0]              rdata_o,
  // mode and pins
  input wire logic [1:0][1:0]         mode_lower_i,
  input wire logic [1:0]              capture_pin_i,
  input wire logic                    external_count_pin_i,
  // timer outputs
  input wire logic [1:0][15:0]        counter_value_o,
  input wire logic [1:0][15:0]        capture_register_o,
  input wire logic [1:0]              capture_flag_set_o,
  input wire logic [1:0]              match_a_o,
  input wire logic [1:0]              match_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ctl_r;
  logic [7:0] tmp_r;
  logic       cnt_wr;
  logic       icr_top;
  ////////////////////////////////////////////////////////////////////////////////
  // shadows; the latch is tracked across both instances since it is shared
  assign cnt_wr  = wr_i && addr_i == 5'h01;
  assign icr_top = ctl_r[4] && !mode_lower_i[0][0];
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_r <= 8'h00;
      tmp_r <= 8'h00;
    end else begin
      if (wr_i && addr_i == 5'h00) begin
        ctl_r <= wdata_i & 8'hdf;
      end
      if (wr_i && !addr_i[4] && addr_i[2:0] inside {3'h2, 3'h4, 3'h6}) begin
        tmp_r <= wdata_i;
      end else if (rd_i && !addr_i[4] && addr_i[2:0] == 3'h1) begin
        tmp_r <= counter_value_o[addr_i[3]][15:8];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  a_stopped_holds: assert property (ctl_r[2:0] == 3'h0 && !cnt_wr |=> $stable(counter_value_o[0]))
    else $error("counter moved while stopped");
  a_div1_counts: assert property (ctl_r[4:0] == 5'h01 && mode_lower_i[0] == 2'h0 && !cnt_wr
    |=> counter_value_o[0] == $past(counter_value_o[0]) + 16'h0001) else $error("undivided count wrong");
  a_rsvd_reads_zero: assert property (rd_i && addr_i == 5'h00 |=> !rdata_o[5])
    else $error("reserved bit read as one");
  a_cnt_write_atomic: assert property (cnt_wr |=> counter_value_o[0] == {$past(tmp_r), $past(wdata_i)})
    else $error("counter write not atomic");
  a_match_blocked: assert property (cnt_wr && ctl_r[2:0] == 3'h1 ##1 ctl_r[2:0] == 3'h1
    |=> !match_a_o[0] && !match_b_o[0]) else $error("match after counter write");
  a_capture_value: assert property (capture_flag_set_o[0] |-> capture_register_o[0] == $past(counter_value_o[0]))
    else $error("captured value wrong");
  a_capture_off: assert property (icr_top [*8] |-> !capture_flag_set_o[0])
    else $error("capture in top mode");
  a_raw_rise_cap: assert property (ctl_r[7:6] == 2'h1 && !icr_top && $rose(capture_pin_i[0])
    |-> ##2 capture_flag_set_o[0]) else $error("raw rising capture late");
  a_filt_rise_cap: assert property (ctl_r[7:6] == 2'h3 && !icr_top && $rose(capture_pin_i[0])
    ##1 capture_pin_i[0] [*3] |-> ##3 capture_flag_set_o[0]) else $error("filtered capture delay wrong");
endmodule : tmcc_timer_chk

bind tmcc_timer_top tmcc_timer_chk i_tmcc_timer_chk (.clk_sys_i, .nrst_i, .addr_i, .wr_i, .rd_i, .wdata_i,
  .rdata_o, .mode_lower_i, .capture_pin_i, .external_count_pin_i, .counter_value_o, .capture_register_o,
  .capture_flag_set_o, .match_a_o, .match_b_o);

/* File: dv/tmcc_timer_top_tb.sv */
// self-checking bench for the dual timer block
`include "tmcc_consts.svh"
module tmcc_timer_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                    clk_sys_i;
  logic                    nrst_i;
  logic [`TMCC_ADDR_W-1:0] addr_i;
  logic                    wr_i;
  logic                    rd_i;
  logic [7:0]              wdata_i;
  logic [7:0]              rdata_o;
  logic [1:0][1:0]         mode_lower_i;
  logic [1:0]              capture_pin_i;
  logic                    external_count_pin_i;
  logic [1:0][15:0]        counter_value_o;
  logic [1:0][15:0]        capture_register_o;
  logic [1:0]              capture_flag_set_o;
  logic [1:0]              match_a_o;
  logic [1:0]              match_b_o;
  int                      errors;
  int                      checked;
  int                      na;
  int                      nb;
  int                      nf;
  int                      lg [8] = '{0, 0, 3, 6, 8, 10, 4, 5};

  tmcc_timer_top i_tmcc_timer_top (.clk_sys_i, .nrst_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
    .mode_lower_i, .capture_pin_i, .external_count_pin_i, .counter_value_o, .capture_register_o,
    .capture_flag_set_o, .match_a_o, .match_b_o);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rdx(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk({8'h00, rdata_o}, {8'h00, e});
  endtask : rdx
  // high byte first so the low write commits both halves
  task automatic w16(input logic [4:0] a_hi, input logic [15:0] v);
    wr(a_hi, v[15:8]);
    wr(a_hi - 5'h01, v[7:0]);
  endtask : w16
  task automatic rd16(input logic [4:0] a_lo, input logic [15:0] e);
    rdx(a_lo, e[7:0]);
    rdx(a_lo + 5'h01, e[15:8]);
  endtask : rd16
  task automatic watch(input int n);
    na = 0;
    nb = 0;
    nf = 0;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
      na += int'(match_a_o[0] === 1'b1);
      nb += int'(match_b_o[0] === 1'b1);
      nf += int'(capture_flag_set_o[0] === 1'b1) + int'(capture_flag_set_o[1] === 1'b1);
    end
  endtask : watch
  task automatic cap(input logic [7:0] c, input logic v, input int e);
    wr(5'h00, c);
    @(posedge clk_sys_i);
    capture_pin_i[0] <= v;
    watch(12);
    chk(16'(nf), 16'(e));
  endtask : cap
  task automatic complete_run();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    errors++;
    complete_run();
  end
  initial begin
    nrst_i = 1'b0;
    addr_i = 5'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    wdata_i = 8'h00;
    mode_lower_i = 4'h0;
    capture_pin_i = 2'h0;
    external_count_pin_i = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    for (int a = 0; a < 16; a++) if (a % 8 != 7) rdx(5'(a), 8'h00);
    $display("test reset done");
    wr(5'h00, 8'hff);
    rdx(5'h00, 8'hdf);
    wr(5'h00, 8'h20);
    rdx(5'h00, 8'h00);
    w16(5'h0a, 16'h1234);
    rd16(5'h09, 16'h1234);
    w16(5'h04, 16'ha5c3);
    rd16(5'h03, 16'ha5c3);
    wr(5'h04, 8'h77);
    wr(5'h09, 8'h55);
    rd16(5'h09, 16'h7755);
    rdx(5'h10, 8'h00);
    $display("test registers done");
    // windows are whole multiples of every division, so counts are exact
    for (int i = 0; i < 2; i++) for (int c = 1; c < 8; c++) if (i == 1 || c < 6) begin
      w16(5'(i * 8 + 2), 16'h0000);
      wr(5'(i * 8), 8'(c));
      repeat (2046) @(posedge clk_sys_i);
      wr(5'(i * 8), 8'h00);
      rd16(5'(i * 8 + 1), 16'(2048 >> lg[c]));
    end
    for (int c = 6; c < 8; c++) begin
      w16(5'h02, 16'h0000);
      wr(5'h00, 8'(c));
      repeat (5) begin
        @(posedge clk_sys_i);
        external_count_pin_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        external_count_pin_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
      end
      // a last rise with no fall tells the two edge codes apart
      external_count_pin_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      wr(5'h00, 8'h00);
      external_count_pin_i <= 1'b0;
      rd16(5'h01, 16'(c - 1));
    end
    // dual slope, top from compare a: 13 ticks run 1,2,3,4,3,2,1,0,1,2,3,4,3
    w16(5'h04, 16'h0004);
    mode_lower_i[0] <= 2'h3;
    w16(5'h02, 16'h0000);
    wr(5'h00, 8'h11);
    repeat (11) @(posedge clk_sys_i);
    wr(5'h00, 8'h00);
    mode_lower_i[0] <= 2'h0;
    rd16(5'h01, 16'h0003);
    $display("test clock select done");
    w16(5'h04, 16'h0010);
    w16(5'h06, 16'h0018);
    wr(5'h00, 8'h01);
    w16(5'h02, 16'h0010);
    watch(20);
    chk(16'(na), 16'h0000);
    chk(16'(nb), 16'h0001);
    w16(5'h02, 16'h0008);
    watch(20);
    chk(16'(na), 16'h0001);
    wr(5'h00, 8'h00);
    $display("test match done");
    w16(5'h02, 16'h0abc);
    cap(8'h40, 1'b1, 1);
    chk(capture_register_o[0], 16'h0abc);
    cap(8'h00, 1'b0, 1);
    cap(8'h00, 1'b1, 0);
    cap(8'hc0, 1'b0, 0);
    @(posedge clk_sys_i);
    capture_pin_i[0] <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    capture_pin_i[0] <= 1'b0;
    watch(12);
    chk(16'(nf), 16'h0000);
    cap(8'hc0, 1'b1, 1);
    cap(8'h50, 1'b0, 0);
    cap(8'h50, 1'b1, 0);
    wr(5'h08, 8'h40);
    @(posedge clk_sys_i);
    capture_pin_i[1] <= 1'b1;
    watch(12);
    chk(16'(nf), 16'h0001);
    chk(capture_register_o[1], 16'h0040);
    $display("test capture done");
    complete_run();
  end
endmodule : tmcc_timer_top_tb

/* File: include/tmcc_cap_if.sv */
// carrier between the timer core and a capture front end
interface tmcc_cap_if;
  logic pin;
  logic filter_en;
  logic rise_sel;
  logic enable;
  logic cap_event;

  modport front (
    input  pin,
    input  filter_en,
    input  rise_sel,
    input  enable,
    output cap_event
  );

  modport core (
    output pin,
    output filter_en,
    output rise_sel,
    output enable,
    input  cap_event
  );
endinterface : tmcc_cap_if

/* File: include/tmcc_consts.svh */
// constants for the dual 16-bit timer/counter block
// What this block does
// - with filter enabled, filtered capture input changes only after four equal samples
// - filter adds exactly four clock cycles to capture recognition
// - edge select bit: zero means falling edge, one means rising edge
// - a qualifying capture trigger copies the 16-bit counter into the capture register
// - a capture trigger also sets the capture flag for the interrupt logic
// - modes using the capture register as top ignore the capture pin
// - clock codes 0..5: stopped, undivided, /8, /64, /256, /1024
// - instance one: code 6 counts falling, code 7 rising edges of external pin
// - external pin edges count even while that pin is driven as output
// - instance three: code 6 divides by 16, code 7 divides by 32
// - counter read and written as two bytes through an 8-bit high-byte latch
// - one high-byte latch serves the counter and compare registers of both instances; the capture register has no port access
// - after a counter write, matches are suppressed on the next timer tick
// - each compare register is compared with the counter on every tick except the first after a counter write
// - compare writes update both bytes at once through the shared latch
// - mode bits of register B and two of register A select sequence and top
`ifndef TMCC_CONSTS_SVH
`define TMCC_CONSTS_SVH

// register port map: bit 3 picks the instance, bits 2:0 the register
`define TMCC_ADDR_W         5
`define TMCC_SUB_CTRLB      3'h0
`define TMCC_SUB_CNT_L      3'h1
`define TMCC_SUB_CNT_H      3'h2
`define TMCC_SUB_CMPA_L     3'h3
`define TMCC_SUB_CMPA_H     3'h4
`define TMCC_SUB_CMPB_L     3'h5
`define TMCC_SUB_CMPB_H     3'h6

// control register b fields
`define TMCC_BIT_FILTER     7
`define TMCC_BIT_EDGE       6
`define TMCC_BIT_RSVD       5
`define TMCC_MODE_HI        4
`define TMCC_MODE_LO        3
`define TMCC_CS_HI          2
`define TMCC_CTRLB_WMASK    8'hdf
`define TMCC_RST_BYTE       8'h00
`define TMCC_RST_WORD       16'h0000

// clock select codes
`define TMCC_CS_STOP        3'h0
`define TMCC_CS_DIV1        3'h1
`define TMCC_CS_DIV8        3'h2
`define TMCC_CS_DIV64       3'h3
`define TMCC_CS_DIV256      3'h4
`define TMCC_CS_DIV1024     3'h5
`define TMCC_CS_CODE6       3'h6
`define TMCC_CS_CODE7       3'h7

// prescaler taps, as log2 of the division
`define TMCC_PRE_W          10
`define TMCC_LOG_DIV8       3
`define TMCC_LOG_DIV16      4
`define TMCC_LOG_DIV32      5
`define TMCC_LOG_DIV64      6
`define TMCC_LOG_DIV256     8
`define TMCC_LOG_DIV1024    10

// fixed top values
`define TMCC_TOP_8BIT       16'h00ff
`define TMCC_TOP_9BIT       16'h01ff
`define TMCC_TOP_10BIT      16'h03ff
`define TMCC_TOP_MAX        16'hffff
`define TMCC_ONE_WORD       16'h0001

// noise filter depth in samples
`define TMCC_FILT_DEPTH     4

`endif

/* File: include/tmcc_pkg.sv */
// types for the dual 16-bit timer/counter block
package tmcc_pkg;

  // capture front end state
  typedef struct packed {
    logic [3:0] hist;
    logic       level;
    logic       event_p;
  } tmcc_front_t;

  // whole state of both timer instances, index 0 is timer one, 1 is timer three
  typedef struct packed {
    logic [1:0][7:0]  ctrlb;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] cmpa;
    logic [1:0][15:0] cmpb;
    logic [1:0][15:0] icr;
    logic [1:0]       dir_down;
    logic [1:0]       blocked;
    logic [1:0]       match_a;
    logic [1:0]       match_b;
    logic [1:0]       cap_set;
    logic [7:0]       temp;
    logic [7:0]       rdata;
    logic             ext_prev;
    logic [9:0]       pre;
  } tmcc_state_t;

endpackage : tmcc_pkg
